// >>> dv/tb.sv
// Self-checking bench for the serial clock and frame format block
`timescale 1ns/10ps
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, e, serial_in_pin, serial_out_pin, serial_out_pin_oe;
    logic link_clock_pin_in, link_clock_pin_out, link_clock_pin_oe;
    logic [15:0] v;
    int nb;
    int n_fail = 0;
    int total_checks = 0;
    int tn[4] = '{5, 7, 9, 8};
    logic [1:0] tp[4] = '{2'h0, 2'h2, 2'h3, 2'h3};
    logic ts[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    logic td[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    logic [8:0] tv[4] = '{9'h015, 9'h05a, 9'h1a5, 9'h0c3};
    usfc_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
        .serial_out_pin_oe(serial_out_pin_oe), .link_clock_pin_in(link_clock_pin_in),
        .link_clock_pin_out(link_clock_pin_out), .link_clock_pin_oe(link_clock_pin_oe));
    usfc_peer u_peer (.pclk(pclk), .line(serial_in_pin), .link_clk(link_clock_pin_in));
    always #5 pclk = ~pclk;
    task automatic summarize();
        if (n_fail == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk1(input logic g, input logic x);
        total_checks++;
        if (g !== x) begin
            n_fail++;
            $display("unexpected at %0t: bit %b, wanted %b", $time, g, x);
        end
    endtask
    task automatic chk32(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            n_fail++;
            $display("unexpected at %0t: word %h, wanted %h", $time, g, x);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        apb(a, 1'b0, 32'h0);
        chk32(q, x);
        chk1(e, xe);
    endtask
    task automatic cfg(input int n, input logic [1:0] par, input logic s2, input logic ds,
        input logic [1:0] sp, input logic b8);
        logic [2:0] cs;
        cs = (n == 9) ? 3'h7 : 3'(n - 5);
        apb(usfc_pkg::OFS_CTRL_A, 1'b1, {30'h0, ds, 1'b0});
        apb(usfc_pkg::OFS_CTRL_C, 1'b1, {25'h0, sp[1], par, s2, cs[1:0], sp[0]});
        apb(usfc_pkg::OFS_CTRL_B, 1'b1, {27'h0, 2'b11, cs[2], 1'b0, b8});
    endtask
    task automatic frame(input int n, input logic [1:0] par, input logic s2, input logic [8:0] d,
        input int bad);
        logic p;
        p = par[0];
        v = '1;
        v[0] = 1'b0;
        for (int i = 0; i < n; i++) begin
            v[i + 1] = d[i];
            p ^= d[i];
        end
        if (par[1]) v[n + 1] = p ^ (bad == 2);
        if (bad == 1 || bad == 3) v[n + 1 + par[1] + (bad == 3)] = 1'b0;
        nb = 2 + n + par[1] + s2;
    endtask
    task automatic sedge(input logic pol);
        while (link_clock_pin_out === pol) @(posedge pclk);
        while (link_clock_pin_out !== pol) @(posedge pclk);
    endtask
    task automatic tx_check(input int len, input logic [1:0] sp);
        if (sp[1]) sedge(sp[0]);
        while (serial_out_pin !== 1'b0) begin
            if (sp[1]) sedge(sp[0]);
            else @(posedge pclk);
        end
        if (!sp[1]) repeat (len / 2) @(posedge pclk);
        for (int i = 0; i <= nb; i++) begin
            chk1(serial_out_pin, v[i]);
            if (sp[1]) sedge(sp[0]);
            else repeat (len) @(posedge pclk);
        end
    endtask
    initial begin
        #300000;
        n_fail++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        chk1(serial_out_pin, 1'b1);
        chk1(link_clock_pin_oe, 1'b0);
        rd(usfc_pkg::OFS_CTRL_C, 32'h6, 1'b0);
        rd(usfc_pkg::OFS_DIV_LOW, 32'h0, 1'b0);
        rd(8'h1c, 32'h0, 1'b1);
        apb(usfc_pkg::OFS_DIV_HIGH, 1'b1, 32'hff);
        rd(usfc_pkg::OFS_DIV_HIGH, 32'hf, 1'b0);
        apb(usfc_pkg::OFS_DIV_HIGH, 1'b1, 32'h0);
        apb(usfc_pkg::OFS_DIV_LOW, 1'b1, 32'h0);
        for (int i = 0; i < 4; i++) begin
            cfg(tn[i], tp[i], ts[i], td[i], 2'b00, tv[i][8]);
            frame(tn[i], tp[i], ts[i], tv[i], 0);
            apb(usfc_pkg::OFS_DATA, 1'b1, {23'h0, tv[i]});
            tx_check(td[i] ? 8 : 16, 2'b00);
            apb(usfc_pkg::OFS_CTRL_A, 1'b0, 32'h0);
            chk1(q[6], 1'b1);
            apb(usfc_pkg::OFS_CTRL_A, 1'b1, {25'h0, 1'b1, 4'h0, td[i], 1'b0});
            apb(usfc_pkg::OFS_CTRL_A, 1'b0, 32'h0);
            chk1(q[6], 1'b0);
        end
        cfg(8, 2'b10, 1'b1, 1'b0, 2'b00, 1'b0);
        for (int b = 0; b < 4; b++) begin
            if (b == 3) apb(usfc_pkg::OFS_CTRL_A, 1'b1, 32'h2);
            frame(8, 2'b10, 1'b1, 9'h03c + 9'(b), b);
            u_peer.send(v, nb, (b == 3) ? 8 : 16, 1'b0);
            apb(usfc_pkg::OFS_CTRL_A, 1'b0, 32'h0);
            chk1(q[7], 1'b1);
            chk1(q[4], b == 1);
            chk1(q[2], b == 2);
            rd(usfc_pkg::OFS_DATA, 32'h3c + 32'(b), 1'b0);
        end
        apb(usfc_pkg::OFS_DIV_LOW, 1'b1, 32'h3);
        for (int p = 0; p < 2; p++) begin
            cfg(8, 2'b00, 1'b0, 1'b0, {1'b1, p[0]}, 1'b0);
            apb(usfc_pkg::OFS_LINK, 1'b1, 32'h1);
            frame(8, 2'b00, 1'b0, 9'h0a5 ^ 9'(p), 0);
            apb(usfc_pkg::OFS_DATA, 1'b1, {23'h0, 9'h0a5 ^ 9'(p)});
            tx_check(0, {1'b1, p[0]});
            chk1(link_clock_pin_oe, 1'b1);
            apb(usfc_pkg::OFS_LINK, 1'b1, 32'h0);
        end
        cfg(8, 2'b00, 1'b0, 1'b0, 2'b10, 1'b0);
        // Drain any late frame so receive complete starts clear
        apb(usfc_pkg::OFS_DATA, 1'b0, 32'h0);
        frame(8, 2'b00, 1'b0, 9'h0c6, 0);
        u_peer.send(v, nb, 8, 1'b1);
        chk1(link_clock_pin_oe, 1'b0);
        apb(usfc_pkg::OFS_CTRL_A, 1'b0, 32'h0);
        chk1(q[7], 1'b1);
        rd(usfc_pkg::OFS_DATA, 32'hc6, 1'b0);
        summarize();
    end
endmodule

// >>> dv/usfc_peer.sv
// Remote serial node model driving the receive line and slave link clock
`timescale 1ns/10ps
module usfc_peer (
    input wire logic pclk,
    output logic line,
    output logic link_clk
);
    initial begin
        line = 1'b1;
        link_clk = 1'b0;
    end
    task automatic send(input logic [15:0] bits, input int n, input int len, input logic sync);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            line <= bits[i];
            link_clk <= sync;
            repeat (len / 2) @(posedge pclk);
            link_clk <= 1'b0;
            repeat (len - len / 2 - 1) @(posedge pclk);
        end
        @(posedge pclk);
        line <= 1'b1;
    endtask
endmodule

// >>> dv/usfc_properties.sv
// Port-level assertions for the serial clock and frame format block
`timescale 1ns/10ps
module usfc_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_in_pin,
    input wire logic serial_out_pin,
    input wire logic serial_out_pin_oe,
    input wire logic link_clock_pin_in,
    input wire logic link_clock_pin_out,
    input wire logic link_clock_pin_oe
);
    logic wr_done;
    logic mapped;
    logic [11:0] div_ff;
    logic [12:0] gap_ff;
    logic armed_ff;
    assign wr_done = psel && penable && pready && pwrite;
    assign mapped = paddr <= usfc_pkg::OFS_LINK && paddr[1:0] == 2'b00;
    // Divisor shadow; gap is only trusted after a toggle with no write since
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 12'h000;
            gap_ff <= 13'h0000;
            armed_ff <= 1'b0;
        end else begin
            gap_ff <= $changed(link_clock_pin_out) ? 13'h0000 : gap_ff + 13'h0001;
            armed_ff <= link_clock_pin_oe && !wr_done && (armed_ff || $changed(link_clock_pin_out));
            if (wr_done && paddr == usfc_pkg::OFS_DIV_LOW) div_ff[7:0] <= pwdata[7:0];
            if (wr_done && paddr == usfc_pkg::OFS_DIV_HIGH) div_ff[11:8] <= pwdata[3:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        !pready ##1 pready;
    endsequence
    AST_ONE_WAIT: assert property (s_setup |=> s_answer)
        else $error("answer not in second access cycle");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    AST_ERR_UNMAPPED: assert property (pready && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    AST_ERR_MAPPED: assert property (pready && mapped |-> !pslverr)
        else $error("mapped access refused");
    AST_READ_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    AST_IDLE_HIGH: assert property (!serial_out_pin_oe |-> serial_out_pin)
        else $error("serial line not idle high");
    AST_LINK_OE_CAUSE: assert property ($changed(link_clock_pin_oe) |-> $past(wr_done) || $past(wr_done, 2))
        else $error("link clock direction moved without a write");
    AST_BAUD_PERIOD: assert property (armed_ff && $changed(link_clock_pin_out) |-> gap_ff == {1'b0, div_ff})
        else $error("link clock half period not divisor plus one");
endmodule
bind usfc_top usfc_properties u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .serial_out_pin_oe(serial_out_pin_oe),
    .link_clock_pin_in(link_clock_pin_in), .link_clock_pin_out(link_clock_pin_out),
    .link_clock_pin_oe(link_clock_pin_oe));

// >>> hw/usfc_baud_gen.sv
// Programmable down-counter baud tick generator
`timescale 1ns/10ps
module usfc_baud_gen #(
    parameter int unsigned W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] divisor,
    input wire logic reload,
    output logic tick
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } usfc_bg_t;
    usfc_bg_t s_ff;
    usfc_bg_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.tick = (s_ff.cnt == '0);
        if (reload || s_ff.cnt == '0) begin
            nxt_s.cnt = divisor;
        end else begin
            nxt_s.cnt = s_ff.cnt - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign tick = s_ff.tick;
endmodule

// >>> hw/usfc_edge_sync.sv
// Two-flop pin synchroniser with edge detector
`timescale 1ns/10ps
module usfc_edge_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } usfc_es_t;
    usfc_es_t s_ff;
    usfc_es_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.meta = pin;
        nxt_s.sync = s_ff.meta;
        nxt_s.prev = s_ff.sync;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= {RESET_LEVEL, RESET_LEVEL, RESET_LEVEL};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign level = s_ff.sync;
    assign rise = s_ff.sync & ~s_ff.prev;
    assign fall = ~s_ff.sync & s_ff.prev;
endmodule

// >>> hw/usfc_pkg.sv
// Constants and types for the serial clock and frame format block
// How it works
// - Down-counter reloads at zero or low write
// - One tick per zero, rate clock over divisor+1
// - Divisor is high nibble and low byte, 0..4095
// - Transmitter divides tick by 16, 8 or 2
// - Receiver steps 16, 8 or 2 states per bit
// - Double speed acts only in asynchronous mode
// - Double speed receiver steps 8 states per bit, one sample
// - Slave clock synchronised then edge detected
// - Link clock pin drives as master, listens as slave
// - Receive sample edge opposite transmit change edge
// - Polarity zero: change rising, sample falling
// - Five to nine data bits, parity, stop bits
// - Start, data LSB first, parity, stop order
// - Next frame follows at once or line idles high
// - One shared frame format for both directions
// - Only first stop bit checked for frame error
// - Parity is data XOR, inverted for odd
// - Pin direction picks internal or external clock
package usfc_pkg;
    localparam int unsigned DIV_W = 12;
    localparam logic [7:0] OFS_DIV_LOW = 8'h00;
    localparam logic [7:0] OFS_DIV_HIGH = 8'h04;
    localparam logic [7:0] OFS_CTRL_A = 8'h08;
    localparam logic [7:0] OFS_CTRL_B = 8'h0c;
    localparam logic [7:0] OFS_CTRL_C = 8'h10;
    localparam logic [7:0] OFS_DATA = 8'h14;
    localparam logic [7:0] OFS_LINK = 8'h18;
    // Control and status A
    localparam int unsigned A_RX_DONE = 7;
    localparam int unsigned A_TX_DONE = 6;
    localparam int unsigned A_BUF_EMPTY = 5;
    localparam int unsigned A_FRAME_ERR = 4;
    localparam int unsigned A_PAR_ERR = 2;
    localparam int unsigned A_DOUBLE = 1;
    // Control and status B
    localparam int unsigned B_RX_EN = 4;
    localparam int unsigned B_TX_EN = 3;
    localparam int unsigned B_CSZ2 = 2;
    localparam int unsigned B_RX_BIT8 = 1;
    localparam int unsigned B_TX_BIT8 = 0;
    // Control and status C, then link direction
    localparam int unsigned C_SYNC = 6;
    localparam int unsigned C_PAR_HI = 5;
    localparam int unsigned C_PAR_LO = 4;
    localparam int unsigned C_STOP2 = 3;
    localparam int unsigned C_CSZ_HI = 2;
    localparam int unsigned C_CSZ_LO = 1;
    localparam int unsigned C_POL = 0;
    localparam int unsigned L_DIR = 0;
    // Reset values
    localparam logic [2:0] CSZ_RESET = 3'h3;
    localparam logic [7:0] DIV_LOW_RESET = 8'h00;
    localparam logic [3:0] DIV_HIGH_RESET = 4'h0;
    // Per-bit state last and mid indices, frame width, receive states
    localparam logic [3:0] OVS_NORMAL_LAST = 4'hf;
    localparam logic [3:0] OVS_DOUBLE_LAST = 4'h7;
    localparam logic [3:0] OVS_NORMAL_MID = 4'h7;
    localparam logic [3:0] OVS_DOUBLE_MID = 4'h3;
    localparam int unsigned FRAME_W = 13;
    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_START = 3'b010,
        RX_BITS = 3'b100
    } usfc_rx_st_t;
endpackage

// >>> hw/usfc_top.sv
// Serial port clock generation, frame format logic and APB registers
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module usfc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_pin_oe,
    input wire logic link_clock_pin_in,
    output logic link_clock_pin_out,
    output logic link_clock_pin_oe
);
    typedef struct packed {
        logic [7:0] div_lo;
        logic [3:0] div_hi;
        logic reload;
        logic dbl;
        logic txen;
        logic rxen;
        logic [2:0] csz;
        logic [1:0] pmode;
        logic stop2;
        logic pol;
        logic sync;
        logic dir;
        logic tx_bit8;
        logic [8:0] tx_buf;
        logic tx_pend;
        logic tx_busy;
        logic [usfc_pkg::FRAME_W-1:0] tx_shift;
        logic [3:0] tx_left;
        logic [3:0] tx_phase;
        logic tx_done;
        logic txd;
        logic txoe;
        logic xck;
        logic xckoe;
        usfc_pkg::usfc_rx_st_t rx_st;
        logic [3:0] rx_phase;
        logic [3:0] rx_idx;
        logic [8:0] rx_sh;
        logic rx_par;
        logic rx_pbad;
        logic [8:0] rx_data;
        logic rx_full;
        logic rx_fe;
        logic rx_pe;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } usfc_st_t;
    usfc_st_t s_ff;
    usfc_st_t nxt_s;

    logic gen_tick;
    logic rxd;
    logic ext_rise;
    logic ext_fall;

    usfc_baud_gen #(
        .W(usfc_pkg::DIV_W)
    ) u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .divisor({s_ff.div_hi, s_ff.div_lo}),
        .reload(s_ff.reload),
        .tick(gen_tick)
    );

    usfc_edge_sync #(
        .RESET_LEVEL(1'b1)
    ) u_rx_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(serial_in_pin),
        .level(rxd),
        .rise(),
        .fall()
    );

    usfc_edge_sync #(
        .RESET_LEVEL(1'b0)
    ) u_xck_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(link_clock_pin_in),
        .level(),
        .rise(ext_rise),
        .fall(ext_fall)
    );

    function automatic logic [3:0] data_bits(input logic [2:0] csz);
        case (csz)
            3'h0: data_bits = 4'h5;
            3'h1: data_bits = 4'h6;
            3'h2: data_bits = 4'h7;
            3'h7: data_bits = 4'h9;
            default: data_bits = 4'h8;
        endcase
    endfunction

    // Even is XOR, odd inverts it
    function automatic logic parity_of(input logic [8:0] d, input logic [3:0] n,
                                       input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n) begin
                p = p ^ d[i];
            end
        end
        parity_of = p;
    endfunction

    // Start, data LSB first, parity, stops
    function automatic logic [usfc_pkg::FRAME_W-1:0] build_frame(input logic [8:0] d,
                                                                input logic [3:0] n,
                                                                input logic pen,
                                                                input logic odd);
        logic [usfc_pkg::FRAME_W-1:0] f;
        f = '1;
        f[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n) begin
                f[i + 1] = d[i];
            end
        end
        if (pen) begin
            f[n + 4'h1] = parity_of(d, n, odd);
        end
        build_frame = f;
    endfunction

    logic master;
    logic slave;
    logic rise;
    logic fall;
    logic change_edge;
    logic sample_edge;
    logic [3:0] nbits;
    logic pen;
    logic [3:0] ovs_last;
    logic [3:0] ovs_mid;
    logic tx_tick;
    logic bit_tick;
    logic acc;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic known;
    logic rx_done_set;
    logic tx_done_set;

    always_comb begin
        nxt_s = s_ff;
        master = s_ff.sync & s_ff.dir;
        slave = s_ff.sync & ~s_ff.dir;
        nxt_s.xckoe = master;
        // Divide by two via clock toggle
        if (master && gen_tick) begin
            nxt_s.xck = ~s_ff.xck;
        end
        rise = master ? (gen_tick & ~s_ff.xck) : (slave & ext_rise);
        fall = master ? (gen_tick & s_ff.xck) : (slave & ext_fall);
        change_edge = s_ff.pol ? fall : rise;
        sample_edge = s_ff.pol ? rise : fall;
        nbits = data_bits(s_ff.csz);
        pen = s_ff.pmode[1];
        ovs_last = s_ff.dbl ? usfc_pkg::OVS_DOUBLE_LAST : usfc_pkg::OVS_NORMAL_LAST;
        ovs_mid = s_ff.dbl ? usfc_pkg::OVS_DOUBLE_MID : usfc_pkg::OVS_NORMAL_MID;

        // Async bit rate by 16 or 8
        if (gen_tick) begin
            nxt_s.tx_phase = (s_ff.tx_phase == ovs_last) ? 4'h0 : s_ff.tx_phase + 4'h1;
        end
        tx_tick = s_ff.sync ? change_edge : (gen_tick && s_ff.tx_phase == ovs_last);

        // Transmit shifter
        tx_done_set = 1'b0;
        nxt_s.txoe = s_ff.txen | s_ff.tx_busy;
        if (tx_tick) begin
            if (s_ff.tx_busy && s_ff.tx_left > 4'h1) begin
                nxt_s.tx_shift = {1'b1, s_ff.tx_shift[usfc_pkg::FRAME_W-1:1]};
                nxt_s.txd = s_ff.tx_shift[1];
                nxt_s.tx_left = s_ff.tx_left - 4'h1;
            end else if (s_ff.tx_pend && s_ff.txen) begin
                nxt_s.tx_shift = build_frame(s_ff.tx_buf, nbits, pen, s_ff.pmode[0]);
                nxt_s.txd = 1'b0;
                nxt_s.tx_left = nbits + {3'h0, pen} + 4'h2 + {3'h0, s_ff.stop2};
                nxt_s.tx_busy = 1'b1;
                nxt_s.tx_pend = 1'b0;
            end else begin
                nxt_s.txd = 1'b1;
                nxt_s.tx_busy = 1'b0;
                tx_done_set = s_ff.tx_busy;
            end
        end

        // Receiver
        rx_done_set = 1'b0;
        bit_tick = 1'b0;
        case (s_ff.rx_st)
            usfc_pkg::RX_IDLE: begin
                nxt_s.rx_phase = 4'h0;
                nxt_s.rx_idx = 4'h0;
                nxt_s.rx_par = s_ff.pmode[0];
                if (s_ff.rxen && !rxd) begin
                    if (s_ff.sync && sample_edge) begin
                        nxt_s.rx_st = usfc_pkg::RX_BITS;
                    end else if (!s_ff.sync && gen_tick) begin
                        nxt_s.rx_st = usfc_pkg::RX_START;
                    end
                end
            end
            usfc_pkg::RX_START: begin
                if (gen_tick) begin
                    nxt_s.rx_phase = s_ff.rx_phase + 4'h1;
                    if (s_ff.rx_phase == ovs_mid) begin
                        nxt_s.rx_phase = 4'h0;
                        nxt_s.rx_st = rxd ? usfc_pkg::RX_IDLE : usfc_pkg::RX_BITS;
                    end
                end
            end
            usfc_pkg::RX_BITS: begin
                if (s_ff.sync) begin
                    bit_tick = sample_edge;
                end else if (gen_tick) begin
                    bit_tick = (s_ff.rx_phase == ovs_last);
                    nxt_s.rx_phase = bit_tick ? 4'h0 : s_ff.rx_phase + 4'h1;
                end
            end
            default: begin
                nxt_s.rx_st = usfc_pkg::RX_IDLE;
            end
        endcase
        if (bit_tick) begin
            nxt_s.rx_idx = s_ff.rx_idx + 4'h1;
            if (s_ff.rx_idx < nbits) begin
                nxt_s.rx_sh[s_ff.rx_idx] = rxd;
                nxt_s.rx_par = s_ff.rx_par ^ rxd;
            end else if (pen && s_ff.rx_idx == nbits) begin
                nxt_s.rx_pbad = s_ff.rx_par ^ rxd;
            end else begin
                rx_done_set = 1'b1;
                nxt_s.rx_data = s_ff.rx_sh;
                nxt_s.rx_fe = ~rxd;
                nxt_s.rx_pe = pen & s_ff.rx_pbad;
                nxt_s.rx_st = usfc_pkg::RX_IDLE;
            end
        end
        if (!pen) begin
            nxt_s.rx_pbad = 1'b0;
        end
        if (!s_ff.rxen) begin
            nxt_s.rx_st = usfc_pkg::RX_IDLE;
        end

        // APB slave, answer in second access cycle
        acc = psel & penable & s_ff.pready;
        wr = acc & pwrite;
        rd = acc & ~pwrite;
        known = 1'b1;
        rdata = 32'h0000_0000;
        case (paddr)
            usfc_pkg::OFS_DIV_LOW: rdata[7:0] = s_ff.div_lo;
            usfc_pkg::OFS_DIV_HIGH: rdata[3:0] = s_ff.div_hi;
            usfc_pkg::OFS_CTRL_A: begin
                rdata[usfc_pkg::A_RX_DONE] = s_ff.rx_full;
                rdata[usfc_pkg::A_TX_DONE] = s_ff.tx_done;
                rdata[usfc_pkg::A_BUF_EMPTY] = ~s_ff.tx_pend;
                rdata[usfc_pkg::A_FRAME_ERR] = s_ff.rx_fe;
                rdata[usfc_pkg::A_PAR_ERR] = s_ff.rx_pe;
                rdata[usfc_pkg::A_DOUBLE] = s_ff.dbl;
            end
            usfc_pkg::OFS_CTRL_B: begin
                rdata[usfc_pkg::B_RX_EN] = s_ff.rxen;
                rdata[usfc_pkg::B_TX_EN] = s_ff.txen;
                rdata[usfc_pkg::B_CSZ2] = s_ff.csz[2];
                rdata[usfc_pkg::B_RX_BIT8] = s_ff.rx_data[8];
                rdata[usfc_pkg::B_TX_BIT8] = s_ff.tx_bit8;
            end
            usfc_pkg::OFS_CTRL_C: begin
                rdata[usfc_pkg::C_SYNC] = s_ff.sync;
                rdata[usfc_pkg::C_PAR_HI:usfc_pkg::C_PAR_LO] = s_ff.pmode;
                rdata[usfc_pkg::C_STOP2] = s_ff.stop2;
                rdata[usfc_pkg::C_CSZ_HI:usfc_pkg::C_CSZ_LO] = s_ff.csz[1:0];
                rdata[usfc_pkg::C_POL] = s_ff.pol;
            end
            usfc_pkg::OFS_DATA: rdata[7:0] = s_ff.rx_data[7:0];
            usfc_pkg::OFS_LINK: rdata[usfc_pkg::L_DIR] = s_ff.dir;
            default: known = 1'b0;
        endcase
        nxt_s.pready = psel & penable & ~s_ff.pready;
        nxt_s.pslverr = psel & penable & ~s_ff.pready & ~known;
        if (psel && penable && !s_ff.pready) begin
            nxt_s.prdata = pwrite ? 32'h0000_0000 : rdata;
        end
        nxt_s.reload = wr && paddr == usfc_pkg::OFS_DIV_LOW;
        if (wr) begin
            case (paddr)
                usfc_pkg::OFS_DIV_LOW: nxt_s.div_lo = pwdata[7:0];
                usfc_pkg::OFS_DIV_HIGH: nxt_s.div_hi = pwdata[3:0];
                usfc_pkg::OFS_CTRL_A: begin
                    nxt_s.dbl = pwdata[usfc_pkg::A_DOUBLE];
                    if (pwdata[usfc_pkg::A_TX_DONE]) begin
                        nxt_s.tx_done = 1'b0;
                    end
                end
                usfc_pkg::OFS_CTRL_B: begin
                    nxt_s.rxen = pwdata[usfc_pkg::B_RX_EN];
                    nxt_s.txen = pwdata[usfc_pkg::B_TX_EN];
                    nxt_s.csz[2] = pwdata[usfc_pkg::B_CSZ2];
                    nxt_s.tx_bit8 = pwdata[usfc_pkg::B_TX_BIT8];
                end
                usfc_pkg::OFS_CTRL_C: begin
                    nxt_s.sync = pwdata[usfc_pkg::C_SYNC];
                    nxt_s.pmode = pwdata[usfc_pkg::C_PAR_HI:usfc_pkg::C_PAR_LO];
                    nxt_s.stop2 = pwdata[usfc_pkg::C_STOP2];
                    nxt_s.csz[1:0] = pwdata[usfc_pkg::C_CSZ_HI:usfc_pkg::C_CSZ_LO];
                    nxt_s.pol = pwdata[usfc_pkg::C_POL];
                end
                usfc_pkg::OFS_DATA: begin
                    nxt_s.tx_buf = {s_ff.tx_bit8, pwdata[7:0]};
                    nxt_s.tx_pend = 1'b1;
                end
                usfc_pkg::OFS_LINK: nxt_s.dir = pwdata[usfc_pkg::L_DIR];
                default: nxt_s.dir = s_ff.dir;
            endcase
        end
        if (rd && paddr == usfc_pkg::OFS_DATA) begin
            nxt_s.rx_full = 1'b0;
        end
        // Hardware set wins over software clear
        if (rx_done_set) begin
            nxt_s.rx_full = 1'b1;
        end
        if (tx_done_set && !(s_ff.tx_pend && s_ff.txen)) begin
            nxt_s.tx_done = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
            s_ff.div_lo <= usfc_pkg::DIV_LOW_RESET;
            s_ff.div_hi <= usfc_pkg::DIV_HIGH_RESET;
            s_ff.csz <= usfc_pkg::CSZ_RESET;
            s_ff.txd <= 1'b1;
            s_ff.rx_par <= 1'b0;
            s_ff.rx_st <= usfc_pkg::RX_IDLE;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign prdata = s_ff.prdata;
    assign pready = s_ff.pready;
    assign pslverr = s_ff.pslverr;
    assign serial_out_pin = s_ff.txd;
    assign serial_out_pin_oe = s_ff.txoe;
    assign link_clock_pin_out = s_ff.xck;
    assign link_clock_pin_oe = s_ff.xckoe;
endmodule
